// ### include/cd_pkg.sv
package cd_pkg;

  // clock and oscillator timing
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned OSC_FREQ_HZ = 25_000;
  localparam int unsigned OSC_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int CNT_W = 16;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DUTY = 4'h4;
  localparam logic [3:0] REG_PERIOD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // control field positions and reset value
  localparam int CTRL_FWD = 0;
  localparam int CTRL_SEL60 = 1;
  localparam int CTRL_RUN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h5;
  localparam logic [CNT_W-1:0] DUTY_RESET = 16'h0000;

  // status field positions
  localparam int STAT_SECTOR = 0;
  localparam int STAT_INVALID = 3;
  localparam int STAT_LOWER = 4;
  localparam int STAT_UPPER = 5;
  localparam int STAT_HALL = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SECTOR_NONE = 3'h7;

  // bit 0 is phase a, bit 1 phase b, bit 2 phase c
  typedef struct packed {
    logic [2:0] top_n;
    logic [2:0] bot;
  } cd_drive_t;

  typedef struct packed {
    logic fwd;
    logic sel60;
    logic run;
  } cd_ctrl_t;

endpackage : cd_pkg

// ### rtl/cd_commutation_decoder.sv
`timescale 1ns/100ps
module cd_commutation_decoder import cd_pkg::*; #(
  parameter int unsigned OSC_PERIOD = OSC_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HALL_IN_A,
  input wire logic HALL_IN_B,
  input wire logic HALL_IN_C,
  input wire logic CURRENT_TRIP,
  output logic PHASE_A_HIGH_DRIVE_N,
  output logic PHASE_B_HIGH_DRIVE_N,
  output logic PHASE_C_HIGH_DRIVE_N,
  output logic PHASE_A_LOW_DRIVE,
  output logic PHASE_B_LOW_DRIVE,
  output logic PHASE_C_LOW_DRIVE,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam logic [CNT_W-1:0] PERIOD_RESET = CNT_W'(OSC_PERIOD);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [3:0] pins_sync;
  logic [2:0] hall;
  logic trip;

  cd_sync #(.W(4)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({CURRENT_TRIP, HALL_IN_C, HALL_IN_B, HALL_IN_A}),
    .q(pins_sync)
  );

  assign hall = pins_sync[2:0];
  assign trip = pins_sync[3];

  ////////////////////////////////////////////////////////////////////////////
  // register file over axi4-lite

  cd_ctrl_t ctrl, next_ctrl;
  logic [CNT_W-1:0] duty, next_duty;
  logic [CNT_W-1:0] period, next_period;
  logic aw_full, next_aw_full;
  logic w_full, next_w_full;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [31:0] status;
  logic do_write;

  assign S_AXI_AWREADY = !aw_full;
  assign S_AXI_WREADY = !w_full;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;
  // write commits once both halves are held and the last response is gone
  assign do_write = aw_full && w_full && !bvalid;

  always_comb begin
    next_ctrl = ctrl;
    next_duty = duty;
    next_period = period;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (S_AXI_AWVALID && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case ({aw_addr[3:2], 2'b00})
        REG_CTRL: begin
          if (w_strb[0]) begin
            next_ctrl.fwd = w_data[CTRL_FWD];
            next_ctrl.sel60 = w_data[CTRL_SEL60];
            next_ctrl.run = w_data[CTRL_RUN];
          end
        end
        REG_DUTY: begin
          if (w_strb[0]) next_duty[7:0] = w_data[7:0];
          if (w_strb[1]) next_duty[15:8] = w_data[15:8];
        end
        REG_PERIOD: begin
          if (w_strb[0]) next_period[7:0] = w_data[7:0];
          if (w_strb[1]) next_period[15:8] = w_data[15:8];
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case ({S_AXI_ARADDR[3:2], 2'b00})
        REG_CTRL: next_rdata = {29'h0, ctrl.run, ctrl.sel60, ctrl.fwd};
        REG_DUTY: next_rdata = {16'h0, duty};
        REG_PERIOD: next_rdata = {16'h0, period};
        REG_STATUS: next_rdata = status;
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    if (RST) begin
      next_ctrl = cd_ctrl_t'(CTRL_RESET);
      next_duty = DUTY_RESET;
      next_period = PERIOD_RESET;
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_aw_addr = 4'h0;
      next_w_data = 32'h0;
      next_w_strb = 4'h0;
      next_bvalid = 1'b0;
      next_bresp = RESP_OKAY;
      next_rvalid = 1'b0;
      next_rdata = 32'h0;
      next_rresp = RESP_OKAY;
    end
  end

  always_ff @(posedge CLK) begin
    ctrl <= next_ctrl;
    duty <= next_duty;
    period <= next_period;
    aw_full <= next_aw_full;
    w_full <= next_w_full;
    aw_addr <= next_aw_addr;
    w_data <= next_w_data;
    w_strb <= next_w_strb;
    bvalid <= next_bvalid;
    bresp <= next_bresp;
    rvalid <= next_rvalid;
    rdata <= next_rdata;
    rresp <= next_rresp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotor position decode

  logic [2:0] sector;
  logic code_ok;

  // sector 0..5 in forward order; invalid codes return SECTOR_NONE
  always_comb begin
    sector = SECTOR_NONE;
    if (ctrl.sel60) begin
      unique case (hall)
        3'h1: sector = 3'h0;
        3'h3: sector = 3'h1;
        3'h7: sector = 3'h2;
        3'h6: sector = 3'h3;
        3'h4: sector = 3'h4;
        3'h0: sector = 3'h5;
        default: sector = SECTOR_NONE;
      endcase
    end else begin
      unique case (hall)
        3'h1: sector = 3'h0;
        3'h3: sector = 3'h1;
        3'h2: sector = 3'h2;
        3'h6: sector = 3'h3;
        3'h4: sector = 3'h4;
        3'h5: sector = 3'h5;
        default: sector = SECTOR_NONE;
      endcase
    end
  end

  assign code_ok = (sector != SECTOR_NONE);

  // one-hot phase selects, forward direction
  logic [2:0] sel_hi, sel_lo;

  always_comb begin
    sel_hi = 3'h0;
    sel_lo = 3'h0;
    unique case (sector)
      3'h0: begin sel_hi = 3'h1; sel_lo = 3'h4; end
      3'h1: begin sel_hi = 3'h2; sel_lo = 3'h4; end
      3'h2: begin sel_hi = 3'h2; sel_lo = 3'h1; end
      3'h3: begin sel_hi = 3'h4; sel_lo = 3'h1; end
      3'h4: begin sel_hi = 3'h4; sel_lo = 3'h2; end
      3'h5: begin sel_hi = 3'h1; sel_lo = 3'h2; end
      default: begin sel_hi = 3'h0; sel_lo = 3'h0; end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator and dual latch pwm

  logic [CNT_W-1:0] cnt, next_cnt;
  logic upper, next_upper;
  logic lower, next_lower;
  cd_drive_t drv, next_drv;
  logic [2:0] on_hi, on_lo;

  always_comb begin
    next_cnt = cnt + 16'h0001;
    next_upper = upper;
    next_lower = lower;
    if (cnt >= period - 16'h0001) begin
      next_cnt = 16'h0000;
    end
    // latches are only set at cycle start, so a pulse cannot restart
    if (cnt == 16'h0000) begin
      next_upper = 1'b1;
      next_lower = 1'b1;
    end
    if (next_cnt >= duty) begin
      next_upper = 1'b0;
    end
    if (trip) begin
      next_lower = 1'b0;
    end
    if (RST) begin
      next_cnt = 16'h0000;
      next_upper = 1'b0;
      next_lower = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive outputs

  always_comb begin
    on_hi = ctrl.fwd ? sel_hi : sel_lo;
    on_lo = ctrl.fwd ? sel_lo : sel_hi;
    next_drv.top_n = ~on_hi;
    next_drv.bot = (upper && lower) ? on_lo : 3'h0;
    if (!lower) begin
      next_drv.top_n = 3'h7;
      next_drv.bot = 3'h0;
    end
    if (!ctrl.run) begin
      next_drv.top_n = 3'h7;
      next_drv.bot = 3'h0;
    end
    if (!code_ok || RST) begin
      next_drv.top_n = 3'h7;
      next_drv.bot = 3'h0;
    end
  end

  always_ff @(posedge CLK) begin
    cnt <= next_cnt;
    upper <= next_upper;
    lower <= next_lower;
    drv <= next_drv;
  end

  assign status = {21'h0, hall, 2'h0, upper, lower, !code_ok, sector};

  assign PHASE_A_HIGH_DRIVE_N = drv.top_n[0];
  assign PHASE_B_HIGH_DRIVE_N = drv.top_n[1];
  assign PHASE_C_HIGH_DRIVE_N = drv.top_n[2];
  assign PHASE_A_LOW_DRIVE = drv.bot[0];
  assign PHASE_B_LOW_DRIVE = drv.bot[1];
  assign PHASE_C_LOW_DRIVE = drv.bot[2];

endmodule : cd_commutation_decoder

// ### rtl/cd_sync.sv
`timescale 1ns/100ps
module cd_sync import cd_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
    if (rst) begin
      next_meta = '0;
      next_q = '0;
    end
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end

endmodule : cd_sync

// ### tb/cd_chk.sv
`timescale 1ns/100ps
module cd_chk import cd_pkg::*; #(
  parameter int unsigned OSC_PERIOD = OSC_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CURRENT_TRIP,
  input wire logic PHASE_A_HIGH_DRIVE_N,
  input wire logic PHASE_B_HIGH_DRIVE_N,
  input wire logic PHASE_C_HIGH_DRIVE_N,
  input wire logic PHASE_A_LOW_DRIVE,
  input wire logic PHASE_B_LOW_DRIVE,
  input wire logic PHASE_C_LOW_DRIVE,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire logic [2:0] tops_n = {PHASE_C_HIGH_DRIVE_N, PHASE_B_HIGH_DRIVE_N, PHASE_A_HIGH_DRIVE_N};
  wire logic [2:0] bots = {PHASE_C_LOW_DRIVE, PHASE_B_LOW_DRIVE, PHASE_A_LOW_DRIVE};
  ////////////////////////////////////////
  // two sync flops, the latch and the drive register: four samples before the trip bites
  sequence s_trip_held;
    CURRENT_TRIP [*4];
  endsequence
  sequence s_read_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_top_single: assert property ($countones(~tops_n) <= 1)
    else $error("two top drives on");
  a_bot_single: assert property ($countones(bots) <= 1)
    else $error("two bottom drives on");
  a_no_shoot: assert property ((~tops_n & bots) == 3'h0)
    else $error("one phase driven both ways");
  a_trip_off: assert property (s_trip_held |=> tops_n == 3'h7 && bots == 3'h0)
    else $error("drives on after trip");
  a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
    && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  a_rvalid_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read answer dropped");
  a_read_answer: assert property (s_read_taken |=> S_AXI_RVALID)
    else $error("read answer late");
  a_read_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
endmodule : cd_chk
bind cd_commutation_decoder cd_chk #(.OSC_PERIOD(OSC_PERIOD)) chk_u (.*);

// ### tb/cd_hall_model.sv
`timescale 1ns/100ps
module cd_hall_model import cd_pkg::*; (
  input wire logic sel60,
  input wire logic [2:0] step,
  output logic hall_a,
  output logic hall_b,
  output logic hall_c
);
  // steps 0..5 walk the rotor forward, 6 and 7 mimic a broken sensor line
  always_comb begin
    case (step)
      3'h0: {hall_a, hall_b, hall_c} = 3'h4;
      3'h1: {hall_a, hall_b, hall_c} = 3'h6;
      3'h2: {hall_a, hall_b, hall_c} = sel60 ? 3'h7 : 3'h2;
      3'h3: {hall_a, hall_b, hall_c} = 3'h3;
      3'h4: {hall_a, hall_b, hall_c} = 3'h1;
      3'h5: {hall_a, hall_b, hall_c} = sel60 ? 3'h0 : 3'h5;
      3'h6: {hall_a, hall_b, hall_c} = sel60 ? 3'h5 : 3'h7;
      default: {hall_a, hall_b, hall_c} = sel60 ? 3'h2 : 3'h0;
    endcase
  end
endmodule : cd_hall_model

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import cd_pkg::*; ;
  localparam int PER = 40;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CURRENT_TRIP = 1'b0;
  logic HALL_IN_A, HALL_IN_B, HALL_IN_C;
  logic PHASE_A_HIGH_DRIVE_N, PHASE_B_HIGH_DRIVE_N, PHASE_C_HIGH_DRIVE_N;
  logic PHASE_A_LOW_DRIVE, PHASE_B_LOW_DRIVE, PHASE_C_LOW_DRIVE;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, sel60 = 1'b1;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
  logic [2:0] step = 3'h0;
  int mismatches = 0;
  int total_checks = 0;
  always #2.5 CLK = ~CLK;
  cd_commutation_decoder #(.OSC_PERIOD(PER)) dut_u (.*);
  cd_hall_model hall_u (.sel60(sel60), .step(step), .hall_a(HALL_IN_A), .hall_b(HALL_IN_B),
    .hall_c(HALL_IN_C));
  ////////////////////////////////////////
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_drv(input logic [5:0] exp);
    check_reg({26'h0, PHASE_C_HIGH_DRIVE_N, PHASE_B_HIGH_DRIVE_N, PHASE_A_HIGH_DRIVE_N,
      PHASE_C_LOW_DRIVE, PHASE_B_LOW_DRIVE, PHASE_A_LOW_DRIVE}, {26'h0, exp});
  endtask : check_drv
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : wait_cyc
  // sector s: forward top a,b,b,c,c,a and bottom c,c,a,a,b,b; reverse swaps
  function automatic logic [5:0] exp_drv(input logic fwd, input int s);
    int t;
    int b;
    if (s > 5) return 6'h38;
    t = fwd ? (s + 1) / 2 % 3 : (s + 4) / 2 % 3;
    b = fwd ? (s + 4) / 2 % 3 : (s + 1) / 2 % 3;
    return {~(3'h1 << t), 3'h1 << b};
  endfunction : exp_drv
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 99);
    rr = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (n > 98) mismatches++;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 99);
    rd = S_AXI_RDATA;
    rr = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    if (n > 98) mismatches++;
  endtask : reg_rd
  ////////////////////////////////////////
  task automatic t_regs();
    reg_rd(REG_CTRL);
    check_reg(rd, 32'h5);
    reg_rd(REG_DUTY);
    check_reg(rd, 32'h0);
    reg_rd(REG_PERIOD);
    check_reg(rd, 32'(PER));
    // low address bits are ignored, so byte 2 aliases the control word
    reg_rd(4'h2);
    check_reg({30'h0, rr}, {30'h0, RESP_OKAY});
    check_reg(rd, 32'h5);
    reg_wr(REG_STATUS, 32'h0);
    check_reg({30'h0, rr}, {30'h0, RESP_SLVERR});
  endtask : t_regs
  task automatic t_table();
    reg_wr(REG_DUTY, 32'hffff);
    wait_cyc(PER);
    for (int m = 0; m < 4; m++) begin
      sel60 <= m[1];
      reg_wr(REG_CTRL, {29'h0, 1'b1, m[1], m[0]});
      for (int s = 0; s < 8; s++) begin
        step <= 3'(s);
        wait_cyc(4);
        check_drv(exp_drv(m[0], s));
      end
    end
  endtask : t_table
  task automatic t_coast();
    step <= 3'h0;
    reg_wr(REG_CTRL, 32'h3);
    reg_rd(REG_CTRL);
    check_reg(rd, 32'h3);
    wait_cyc(4);
    check_drv(6'h38);
    reg_wr(REG_CTRL, 32'h7);
    wait_cyc(4);
    check_drv(exp_drv(1'b1, 0));
  endtask : t_coast
  task automatic t_pwm(input int d);
    int hi;
    int rise;
    int on;
    logic prev;
    hi = 0;
    rise = 0;
    on = 0;
    reg_wr(REG_DUTY, 32'(d));
    wait_cyc(PER);
    prev = PHASE_C_LOW_DRIVE;
    for (int i = 0; i < PER; i++) begin
      @(posedge CLK);
      hi += PHASE_C_LOW_DRIVE;
      rise += PHASE_C_LOW_DRIVE && !prev;
      on += !PHASE_A_HIGH_DRIVE_N;
      prev = PHASE_C_LOW_DRIVE;
    end
    check_reg(32'(hi <= d + d / 10 && hi + d / 10 >= d), 32'h1);
    check_reg(32'(rise), 32'(d != 0));
    check_reg(32'(on), 32'(PER));
  endtask : t_pwm
  // trip raised just after a cycle starts, so the wrap is far off
  task automatic t_trip();
    int n;
    n = 0;
    reg_wr(REG_DUTY, 32'h14);
    while (PHASE_C_LOW_DRIVE !== 1'b0 && n < 99) begin
      @(posedge CLK);
      n++;
    end
    while (PHASE_C_LOW_DRIVE !== 1'b1 && n < 199) begin
      @(posedge CLK);
      n++;
    end
    CURRENT_TRIP <= 1'b1;
    wait_cyc(4);
    CURRENT_TRIP <= 1'b0;
    wait_cyc(2);
    check_drv(6'h38);
    wait_cyc(15);
    check_drv(6'h38);
    wait_cyc(25);
    check_drv(exp_drv(1'b1, 0));
  endtask : t_trip
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_table();
    t_coast();
    t_pwm(0);
    t_pwm(10);
    t_trip();
    tally_and_finish();
  end
  // whole run is near five hundred cycles
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_top
